/* File: logic/slc_regs.sv */
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module slc_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hclk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Shared halt line, open drain, active low
  input wire logic halt_line_n_in,
  output logic halt_line_n_out,
  output logic halt_line_n_oe_n,
  // Per-tile core halt state and debug request
  input wire logic [1:0] core_in_halt_state,
  output logic [1:0] core_debug_req,
  // Link status feeds
  input wire slc_pkg::slc_lstat_t [7:0] xlink_stat,
  input wire slc_pkg::slc_lstat_t [7:0] processor_link_stat,
  input wire slc_pkg::slc_xmon_t [7:0] xlink_mon,
  // Link settings and one-cycle commands
  output slc_pkg::slc_xcfg_t [7:0] xlink_cfg,
  output logic [7:0][1:0] processor_link_network,
  output logic [7:0] xlink_greet,
  output logic [7:0] xlink_rx_reset,
  output slc_pkg::slc_static_t [7:0] static_cfg
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pin_meta; // First synchroniser stage
    logic pin_sync; // Second synchroniser stage
    logic halt_prev; // Halt line asserted last cycle
    logic drive; // We pull the halt line low
    logic [1:0] dbg_req; // Requests to the cores
    logic wlock; // Control target write lock
    logic [1:0][1:0] dbg_cfg; // Per tile: request enable, drive enable
    logic [4:0] cause; // Last halt event cause
    slc_pkg::slc_xcfg_t [7:0] xcfg; // External link settings
    logic [7:0][1:0] pnet; // Processor link networks
    slc_pkg::slc_static_t [7:0] sfwd; // Static forward slots
    logic [7:0] greet; // Greeting pulses
    logic [7:0] rxrst; // Receiver reset pulses
    logic dp_sel; // Data phase pending
    logic dp_wr; // Pending transfer is a write
    logic dp_ok; // Address inside the block window
    logic [7:0] dp_idx; // Pending register index
    logic rd_wait; // Read data captured, answer now
    logic [31:0] rdata; // Registered read data
  } slc_state_t;

  slc_state_t s_reg;
  slc_state_t s_next;

  // Combinational helpers
  logic halt_asserted; // Line seen low, ours or external
  logic drive_now; // Some enabled core is halting
  logic halt_event; // New assertion of the halt line
  logic [31:0] rd_mux; // Read value of the pending index
  logic [2:0] slot; // Low index bits pick link slot
  logic [7:0] blk; // Index with slot bits masked

  // ----------------------------------------------------------------
  // Output wiring
  // ----------------------------------------------------------------
  // Reads take one wait state so hrdata always comes from a flop and a
  // write followed at once by a read of the same word sees the new value
  assign hreadyout = !(s_reg.dp_sel && !s_reg.dp_wr && !s_reg.rd_wait);
  assign hresp = 1'b0;
  assign hrdata = s_reg.rdata;
  assign halt_line_n_out = 1'b0;
  assign halt_line_n_oe_n = !s_reg.drive;
  assign core_debug_req = s_reg.dbg_req;
  assign xlink_greet = s_reg.greet;
  assign xlink_rx_reset = s_reg.rxrst;

  // Per-link settings out; static slots land on their lettered link
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_link
      assign xlink_cfg[gi] = s_reg.xcfg[gi];
      assign processor_link_network[gi] = s_reg.pnet[gi];
      assign static_cfg[slc_pkg::STATIC_LINK_MAP[gi]] = s_reg.sfwd[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Halt line logic, bus decode, register writes and read mux
  always_comb begin
    s_next = s_reg;
    slot = s_reg.dp_idx[2:0];
    blk = s_reg.dp_idx & slc_pkg::IDX_BLK_MASK;

    // Pin synchroniser; only the second stage is read
    s_next.pin_meta = halt_line_n_in;
    s_next.pin_sync = s_reg.pin_meta;

    // A core drives the line only while halting and allowed to
    drive_now = 1'b0;
    for (int t = 0; t < 2; t++) begin
      drive_now = drive_now |
                  (core_in_halt_state[t] & s_reg.dbg_cfg[t][slc_pkg::DBG_DRIVE_EN_BIT]);
    end
    s_next.drive = drive_now;

    // Our own drive shows up in the pin late, so count it directly
    halt_asserted = !s_reg.pin_sync || s_reg.drive;
    s_next.halt_prev = halt_asserted;
    halt_event = halt_asserted && !s_reg.halt_prev;

    // Requests follow the line for enabled tiles
    for (int t = 0; t < 2; t++) begin
      s_next.dbg_req[t] = halt_asserted & s_reg.dbg_cfg[t][slc_pkg::DBG_REQ_EN_BIT];
    end

    // Command pulses last one cycle
    s_next.greet = '0;
    s_next.rxrst = '0;

    // Read mux, reserved bits zero
    rd_mux = slc_pkg::RDATA_NONE;
    if (!s_reg.dp_ok) begin
      rd_mux = slc_pkg::RDATA_NONE;
    end else if (s_reg.dp_idx == slc_pkg::IDX_SW_CFG) begin
      rd_mux[slc_pkg::SW_LOCK_BIT] = s_reg.wlock;
    end else if (s_reg.dp_idx == slc_pkg::IDX_DBG_T0 ||
                 s_reg.dp_idx == slc_pkg::IDX_DBG_T1) begin
      rd_mux[1:0] = s_reg.dbg_cfg[s_reg.dp_idx[0]];
    end else if (s_reg.dp_idx == slc_pkg::IDX_DBG_SRC) begin
      rd_mux[4:0] = s_reg.cause;
    end else if (blk == slc_pkg::IDX_LSTAT) begin
      // Switch link status: live flags plus direction and network
      rd_mux[slc_pkg::ST_KIND_LSB +: 2] = xlink_stat[slot].kind;
      rd_mux[slc_pkg::ST_DEST_LSB +: 8] = xlink_stat[slot].dest;
      rd_mux[slc_pkg::ST_DIR_LSB +: 4] = s_reg.xcfg[slot].direction;
      rd_mux[slc_pkg::ST_NET_LSB +: 2] = s_reg.xcfg[slot].network;
      rd_mux[slc_pkg::ST_JUNK_BIT] = xlink_stat[slot].junk;
      rd_mux[slc_pkg::ST_DST_BIT] = xlink_stat[slot].dst_busy;
      rd_mux[slc_pkg::ST_SRC_BIT] = xlink_stat[slot].src_busy;
    end else if (blk == slc_pkg::IDX_PSTAT) begin
      // Processor link status has no direction field
      rd_mux[slc_pkg::ST_KIND_LSB +: 2] = processor_link_stat[slot].kind;
      rd_mux[slc_pkg::ST_DEST_LSB +: 8] = processor_link_stat[slot].dest;
      rd_mux[slc_pkg::ST_NET_LSB +: 2] = s_reg.pnet[slot];
      rd_mux[slc_pkg::ST_JUNK_BIT] = processor_link_stat[slot].junk;
      rd_mux[slc_pkg::ST_DST_BIT] = processor_link_stat[slot].dst_busy;
      rd_mux[slc_pkg::ST_SRC_BIT] = processor_link_stat[slot].src_busy;
    end else if (blk == slc_pkg::IDX_LCFG) begin
      // Write-only command bits read as zero
      rd_mux[slc_pkg::LC_EN_BIT] = s_reg.xcfg[slot].enable;
      rd_mux[slc_pkg::LC_WIDE_BIT] = s_reg.xcfg[slot].five_wire;
      rd_mux[slc_pkg::LC_ERR_BIT] = xlink_mon[slot].rx_error;
      rd_mux[slc_pkg::LC_CR_ISSUED_BIT] = xlink_mon[slot].credit_issued;
      rd_mux[slc_pkg::LC_CR_HELD_BIT] = xlink_mon[slot].credit_held;
      rd_mux[slc_pkg::LC_SYMGAP_LSB +: 11] = s_reg.xcfg[slot].sym_gap;
      rd_mux[slc_pkg::LC_TOKGAP_LSB +: 11] = s_reg.xcfg[slot].tok_gap;
    end else if (blk == slc_pkg::IDX_STATIC) begin
      rd_mux[slc_pkg::SF_EN_BIT] = s_reg.sfwd[slot].enable;
      rd_mux[slc_pkg::SF_PROC_BIT] = s_reg.sfwd[slot].proc;
      rd_mux[slc_pkg::SF_CHAN_LSB +: 5] = s_reg.sfwd[slot].chan_end;
    end

    // Read data phase: first cycle captures, second answers
    if (s_reg.dp_sel && !s_reg.dp_wr && !s_reg.rd_wait) begin
      s_next.rd_wait = 1'b1;
      s_next.rdata = rd_mux;
    end

    // Write data phase; writable fields only
    if (s_reg.dp_sel && s_reg.dp_wr && s_reg.dp_ok) begin
      if (s_reg.dp_idx == slc_pkg::IDX_SW_CFG) begin
        // The lock register itself stays writable so it can be undone
        s_next.wlock = hwdata[slc_pkg::SW_LOCK_BIT];
      end else if (s_reg.wlock) begin
        s_next.wlock = s_reg.wlock;
      end else if (s_reg.dp_idx == slc_pkg::IDX_DBG_T0 ||
                   s_reg.dp_idx == slc_pkg::IDX_DBG_T1) begin
        s_next.dbg_cfg[s_reg.dp_idx[0]] = hwdata[1:0];
      end else if (s_reg.dp_idx == slc_pkg::IDX_DBG_SRC) begin
        s_next.cause = {hwdata[slc_pkg::SRC_PIN_BIT], 2'h0,
                        hwdata[slc_pkg::SRC_CORE1_BIT], hwdata[slc_pkg::SRC_CORE0_BIT]};
      end else if (blk == slc_pkg::IDX_LSTAT) begin
        s_next.xcfg[slot].direction = hwdata[slc_pkg::ST_DIR_LSB +: 4];
        s_next.xcfg[slot].network = hwdata[slc_pkg::ST_NET_LSB +: 2];
      end else if (blk == slc_pkg::IDX_PSTAT) begin
        s_next.pnet[slot] = hwdata[slc_pkg::ST_NET_LSB +: 2];
      end else if (blk == slc_pkg::IDX_LCFG) begin
        s_next.xcfg[slot].enable = hwdata[slc_pkg::LC_EN_BIT];
        s_next.xcfg[slot].five_wire = hwdata[slc_pkg::LC_WIDE_BIT];
        s_next.xcfg[slot].sym_gap = hwdata[slc_pkg::LC_SYMGAP_LSB +: 11];
        s_next.xcfg[slot].tok_gap = hwdata[slc_pkg::LC_TOKGAP_LSB +: 11];
        s_next.greet[slot] = hwdata[slc_pkg::LC_LINK_GREETING_TOKEN_BIT];
        s_next.rxrst[slot] = hwdata[slc_pkg::LC_RXRST_BIT];
      end else if (blk == slc_pkg::IDX_STATIC) begin
        s_next.sfwd[slot].enable = hwdata[slc_pkg::SF_EN_BIT];
        s_next.sfwd[slot].proc = hwdata[slc_pkg::SF_PROC_BIT];
        s_next.sfwd[slot].chan_end = hwdata[slc_pkg::SF_CHAN_LSB +: 5];
      end
    end

    // Hardware event beats a software write in the same cycle
    if (halt_event) begin
      s_next.cause = '0;
      s_next.cause[slc_pkg::SRC_PIN_BIT] = !s_reg.pin_sync && !s_reg.drive;
      s_next.cause[slc_pkg::SRC_CORE1_BIT] =
        core_in_halt_state[1] & s_reg.dbg_cfg[1][slc_pkg::DBG_DRIVE_EN_BIT];
      s_next.cause[slc_pkg::SRC_CORE0_BIT] =
        core_in_halt_state[0] & s_reg.dbg_cfg[0][slc_pkg::DBG_DRIVE_EN_BIT];
    end

    // Address phase; only taken while the bus is ready
    if (hready) begin
      s_next.dp_sel = hsel && (htrans == slc_pkg::HTRANS_NONSEQ || htrans == 2'h3);
      s_next.dp_wr = hwrite;
      s_next.dp_ok = (haddr[31:10] == 22'h00_0000);
      s_next.dp_idx = haddr[slc_pkg::IDX_LSB +: slc_pkg::IDX_W];
      s_next.rd_wait = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Everything freezes while the clock enable is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.pin_meta <= 1'b1;
      s_reg.pin_sync <= 1'b1;
    end else if (hclk_en) begin
      s_reg <= s_next;
    end
  end

endmodule // slc_regs

/* File: logic/slc_pkg.sv */
package slc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_XLINK = 8; // External links 0..7
  localparam int unsigned NUM_PROCESSOR_LINK = 8; // Processor links 0..7
  localparam int unsigned NUM_TILE = 2; // Tiles with a debug config each
  localparam int unsigned IDX_W = 8; // Register index width
  localparam int unsigned IDX_LSB = 2; // Byte address = index * 4

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SW_CFG = 8'h04; // Switch config, write lock
  localparam logic [7:0] IDX_DBG_T0 = 8'h10; // Tile 0 debug pin config
  localparam logic [7:0] IDX_DBG_T1 = 8'h11; // Tile 1 debug pin config
  localparam logic [7:0] IDX_DBG_SRC = 8'h1f; // Last debug cause
  localparam logic [7:0] IDX_LSTAT = 8'h20; // External link status base
  localparam logic [7:0] IDX_PSTAT = 8'h40; // Processor link status base
  localparam logic [7:0] IDX_LCFG = 8'h80; // Link config base
  localparam logic [7:0] IDX_STATIC = 8'ha0; // Static forward base
  localparam logic [7:0] IDX_BLK_MASK = 8'hf8; // Eight-entry block match

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned SW_LOCK_BIT = 31;
  localparam int unsigned DBG_REQ_EN_BIT = 1;
  localparam int unsigned DBG_DRIVE_EN_BIT = 0;
  localparam int unsigned SRC_PIN_BIT = 4;
  localparam int unsigned SRC_CORE1_BIT = 1;
  localparam int unsigned SRC_CORE0_BIT = 0;
  localparam int unsigned ST_KIND_LSB = 24; // 25:24
  localparam int unsigned ST_DEST_LSB = 16; // 23:16
  localparam int unsigned ST_DIR_LSB = 8; // 11:8
  localparam int unsigned ST_NET_LSB = 4; // 5:4
  localparam int unsigned ST_JUNK_BIT = 2;
  localparam int unsigned ST_DST_BIT = 1;
  localparam int unsigned ST_SRC_BIT = 0;
  localparam int unsigned LC_EN_BIT = 31;
  localparam int unsigned LC_WIDE_BIT = 30;
  localparam int unsigned LC_ERR_BIT = 27;
  localparam int unsigned LC_CR_ISSUED_BIT = 26;
  localparam int unsigned LC_CR_HELD_BIT = 25;
  localparam int unsigned LC_LINK_GREETING_TOKEN_BIT = 24;
  localparam int unsigned LC_RXRST_BIT = 23;
  localparam int unsigned LC_SYMGAP_LSB = 11; // 21:11
  localparam int unsigned LC_TOKGAP_LSB = 0; // 10:0
  localparam int unsigned SF_EN_BIT = 31;
  localparam int unsigned SF_PROC_BIT = 8;
  localparam int unsigned SF_CHAN_LSB = 0; // 4:0

  // Source/target kinds reported in link status
  localparam logic [1:0] KIND_SWITCH_LINK = 2'h0;
  localparam logic [1:0] KIND_PROC_LINK = 2'h1;
  localparam logic [1:0] KIND_CTRL_TARGET = 2'h2;

  // Static register slot i serves link letter (A=0 .. H=7): C D A B G H E F
  localparam logic [7:0][2:0] STATIC_LINK_MAP = {3'h5, 3'h4, 3'h7, 3'h6,
                                                 3'h1, 3'h0, 3'h3, 3'h2};

  // AHB constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Live status from one switch or processor link
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] dest;
    logic junk;
    logic dst_busy;
    logic src_busy;
  } slc_lstat_t;

  // Live state reported by one external link transceiver
  typedef struct packed {
    logic rx_error;
    logic credit_issued;
    logic credit_held;
  } slc_xmon_t;

  // Stored settings of one external link
  typedef struct packed {
    logic enable;
    logic five_wire;
    logic [10:0] sym_gap;
    logic [10:0] tok_gap;
    logic [3:0] direction;
    logic [1:0] network;
  } slc_xcfg_t;

  // Static forwarding settings of one link
  typedef struct packed {
    logic enable;
    logic proc;
    logic [4:0] chan_end;
  } slc_static_t;

  localparam slc_xcfg_t XCFG_RESET = '0;
  localparam slc_static_t STATIC_RESET = '0;

endpackage

/* File: verification/slc_regs_chk.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Port checker for the register bank
// ---------------------------------------------
module slc_regs_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic halt_line_n_in,
  input wire logic halt_line_n_out,
  input wire logic halt_line_n_oe_n,
  input wire logic [1:0] core_in_halt_state,
  input wire logic [1:0] core_debug_req,
  input wire slc_pkg::slc_xcfg_t [7:0] xlink_cfg,
  input wire logic [7:0] xlink_greet,
  input wire logic [7:0] xlink_rx_reset,
  input wire slc_pkg::slc_static_t [7:0] static_cfg
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic dp; // Data phase pending
  logic dw; // Pending phase is a write
  logic lock; // Shadow of the write lock
  logic [7:0] di; // Pending register index
  logic cw; // Write completes this edge
  logic lcw; // Unlocked link config write
  // Track address phases; lock shadow lets us judge ignored writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp <= 1'b0;
      dw <= 1'b0;
      di <= 8'h00;
      lock <= 1'b0;
    end else if (hready) begin
      dp <= hsel && htrans[1] && (haddr[31:10] == 22'h0);
      dw <= hwrite;
      di <= haddr[9:2];
      if (cw && di == slc_pkg::IDX_SW_CFG) begin
        lock <= hwdata[31];
      end
    end
  end
  assign cw = dp && dw && hready;
  assign lcw = cw && !lock && ((di & slc_pkg::IDX_BLK_MASK) == slc_pkg::IDX_LCFG);
  property p_lc_gap;
    lcw |=> xlink_cfg[$past(di[2:0])].sym_gap == $past(hwdata[21:11])
      && xlink_cfg[$past(di[2:0])].tok_gap == $past(hwdata[10:0]);
  endproperty
  a_lc_gap: assert property (p_lc_gap) else $error("gap fields not stored");
  property p_lc_en;
    lcw |=> xlink_cfg[$past(di[2:0])].enable == $past(hwdata[31])
      && xlink_cfg[$past(di[2:0])].five_wire == $past(hwdata[30]);
  endproperty
  a_lc_en: assert property (p_lc_en) else $error("enable or width not stored");
  property p_greet;
    lcw |=> xlink_greet == ($past(hwdata[24]) ? (8'h01 << $past(di[2:0])) : 8'h00);
  endproperty
  a_greet: assert property (p_greet) else $error("greeting pulse wrong");
  property p_rxrst;
    lcw |=> xlink_rx_reset == ($past(hwdata[23]) ? (8'h01 << $past(di[2:0])) : 8'h00);
  endproperty
  a_rxrst: assert property (p_rxrst) else $error("receiver reset pulse wrong");
  property p_stat_wr;
    cw && !lock && ((di & slc_pkg::IDX_BLK_MASK) == slc_pkg::IDX_LSTAT) |=>
      xlink_cfg[$past(di[2:0])].direction == $past(hwdata[11:8])
      && xlink_cfg[$past(di[2:0])].network == $past(hwdata[5:4]);
  endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("direction or network wrong");
  property p_static;
    cw && !lock && ((di & slc_pkg::IDX_BLK_MASK) == slc_pkg::IDX_STATIC) |=>
      static_cfg[slc_pkg::STATIC_LINK_MAP[$past(di[2:0])]] ==
      {$past(hwdata[31]), $past(hwdata[8]), $past(hwdata[4:0])};
  endproperty
  a_static: assert property (p_static) else $error("static forward setting wrong");
  property p_lock;
    cw && lock && di != slc_pkg::IDX_SW_CFG |=> $stable(xlink_cfg) && $stable(static_cfg);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write took effect");
  property p_drive;
    !halt_line_n_oe_n |-> $past(core_in_halt_state) != 2'h0;
  endproperty
  a_drive: assert property (p_drive) else $error("halt line pulled without halt");
  property p_out;
    halt_line_n_out == 1'b0;
  endproperty
  a_out: assert property (p_out) else $error("halt line drive level wrong");
  property p_req;
    $rose(core_debug_req[0]) |-> !$past(halt_line_n_in, 1) || !$past(halt_line_n_in, 2)
      || !$past(halt_line_n_in, 3);
  endproperty
  a_req: assert property (p_req) else $error("request without halt line");
  c_lcw: cover property (lcw);
  c_drive: cover property (!halt_line_n_oe_n);
  c_req1: cover property ($rose(core_debug_req[1]));
endmodule // slc_regs_chk

bind slc_regs slc_regs_chk u_slc_regs_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .halt_line_n_in, .halt_line_n_out, .halt_line_n_oe_n, .core_in_halt_state,
  .core_debug_req, .xlink_cfg, .xlink_greet, .xlink_rx_reset, .static_cfg);

/* File: verification/slc_far.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Far link ends and the shared halt line
// ---------------------------------------------
module slc_far (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] xlink_greet,
  input wire logic [7:0] xlink_rx_reset,
  input wire logic [7:0] err_inject,
  input wire logic halt_line_n_out,
  input wire logic halt_line_n_oe_n,
  input wire logic ext_pin_n,
  output logic halt_line_n,
  output slc_pkg::slc_xmon_t [7:0] xlink_mon
);
  logic [3:0][7:0] gd; // Greetings in flight to the remote end
  logic [7:0] held; // Credit held by this end
  logic [7:0] err; // Sticky receive error
  // Remote answers a greeting with credit four clocks later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gd <= '0;
      held <= 8'hff;
      err <= 8'h00;
    end else begin
      gd <= {gd[2:0], xlink_greet};
      held <= (held & ~xlink_greet) | gd[3];
      err <= (err | err_inject) & ~xlink_rx_reset;
    end
  end
  // Receiver in error withholds credit from the remote end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      xlink_mon[i] = '{rx_error: err[i], credit_issued: !err[i], credit_held: held[i]};
    end
  end
  // Pulled-up line, low when the pin or the device pulls it
  assign halt_line_n = ext_pin_n && (halt_line_n_oe_n || halt_line_n_out);
endmodule // slc_far

/* File: verification/switch_link_debug_config_bench.sv */
`timescale 1ns/1ps
module switch_link_debug_config_bench;
  logic hclk, hresetn, hsel, hwrite, halt_n, oe_n, hout, hreadyout, hresp, ext_n, rd_dp, en;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, halt, req;
  logic [2:0] hsize;
  logic [7:0] greet, rxr, errin;
  logic [7:0][1:0] pnet;
  slc_pkg::slc_lstat_t [7:0] xs, ps;
  slc_pkg::slc_xmon_t [7:0] mon;
  slc_pkg::slc_xcfg_t [7:0] xcfg;
  slc_pkg::slc_static_t [7:0] scfg;
  logic [31:0] q[$]; // Expected read data in issue order
  int seed, err_total, n_tests, cyc;
  slc_regs u_slc_regs (.hclk(hclk), .hresetn(hresetn), .hclk_en(en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .halt_line_n_in(halt_n), .halt_line_n_out(hout), .halt_line_n_oe_n(oe_n),
    .core_in_halt_state(halt), .core_debug_req(req), .xlink_stat(xs), .processor_link_stat(ps),
    .xlink_mon(mon), .xlink_cfg(xcfg), .processor_link_network(pnet), .xlink_greet(greet),
    .xlink_rx_reset(rxr), .static_cfg(scfg));
  slc_far u_slc_far (.hclk(hclk), .hresetn(hresetn), .xlink_greet(greet),
    .xlink_rx_reset(rxr), .err_inject(errin), .halt_line_n_out(hout),
    .halt_line_n_oe_n(oe_n), .ext_pin_n(ext_n), .halt_line_n(halt_n), .xlink_mon(mon));
  // ---------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Generous ceiling; the sequence needs about 340 cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Single transfer; waits on hreadyout, never on a fixed count
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     input logic [31:0] e);
    hsel <= 1'b1;
    htrans <= slc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    if (!w) q.push_back(e);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, 32'h0);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0, e);
  endtask
  function automatic logic [31:0] st(slc_pkg::slc_lstat_t s, logic [3:0] dir, logic [1:0] net);
    return {6'h0, s.kind, s.dest, 4'h0, dir, 2'h0, net, 1'b0, s.junk, s.dst_busy, s.src_busy};
  endfunction
  // Read monitor: oldest note against data at completion
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) check(hrdata, q.pop_front());
    if (hreadyout === 1'b1) rd_dp <= hsel && htrans == slc_pkg::HTRANS_NONSEQ && !hwrite;
  end
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, halt, errin, rd_dp} = '0;
    {ext_n, en, hsize, seed, err_total, n_tests, cyc} = {2'h3, 3'h2, 32'd80422, 96'd0};
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      xs[i] = r[12:0];
      ps[i] = r[28:16];
    end
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(slc_pkg::IDX_DBG_T0, 32'h0);
    rd(slc_pkg::IDX_DBG_T1, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rd(slc_pkg::IDX_LSTAT + i, st(xs[i], 4'h0, 2'h0));
      wr(slc_pkg::IDX_LSTAT + i, 32'hffff_ffff);
      rd(slc_pkg::IDX_LSTAT + i, st(xs[i], 4'hf, 2'h3));
      wr(slc_pkg::IDX_PSTAT + i, 32'hffff_ffff);
      rd(slc_pkg::IDX_PSTAT + i, st(ps[i], 4'h0, 2'h3));
      check(32'(pnet[i]), 32'h3);
    end
    rd(slc_pkg::IDX_LSTAT + 8'h08, 32'h0);
    rd(slc_pkg::IDX_LCFG + 8'h08, 32'h0);
    errin <= 8'hff;
    @(posedge hclk);
    errin <= 8'h00;
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      wr(slc_pkg::IDX_LCFG + i, r);
      // Settings land at the completing edge, so look one edge later at the earliest
      repeat (6) @(posedge hclk);
      check(32'(xcfg[i]), {2'h0, r[31:30], r[21:0], 4'hf, 2'h3});
      rd(slc_pkg::IDX_LCFG + i, {r[31:30], 2'h0, mon[i].rx_error, mon[i].credit_issued,
        mon[i].credit_held, 3'h0, r[21:0]});
    end
    wr(slc_pkg::IDX_SW_CFG, 32'h8000_0000);
    rd(slc_pkg::IDX_SW_CFG, 32'h8000_0000);
    wr(slc_pkg::IDX_STATIC, 32'h8000_011f);
    rd(slc_pkg::IDX_STATIC, 32'h0);
    check(32'(hresp), 32'h0);
    wr(slc_pkg::IDX_SW_CFG, 32'h0);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      wr(slc_pkg::IDX_STATIC + i, r);
      rd(slc_pkg::IDX_STATIC + i, {r[31], 22'h0, r[8], 3'h0, r[4:0]});
      check(32'(scfg[slc_pkg::STATIC_LINK_MAP[i]]), {25'h0, r[31], r[8], r[4:0]});
    end
    wr(slc_pkg::IDX_DBG_T0, 32'hffff_ffff);
    rd(slc_pkg::IDX_DBG_T0, 32'h3);
    wr(slc_pkg::IDX_DBG_T1, 32'h2);
    // Clock enable low: the halting core must not reach the line yet
    en <= 1'b0;
    halt <= 2'b01;
    repeat (6) @(posedge hclk);
    check(32'(req), 32'h0);
    en <= 1'b1;
    repeat (6) @(posedge hclk);
    check(32'(req), 32'h3);
    rd(slc_pkg::IDX_DBG_SRC, 32'h1);
    halt <= 2'b00;
    repeat (6) @(posedge hclk);
    ext_n <= 1'b0;
    repeat (6) @(posedge hclk);
    check(32'(req), 32'h3);
    rd(slc_pkg::IDX_DBG_SRC, 32'h10);
    ext_n <= 1'b1;
    wr(slc_pkg::IDX_DBG_T0, 32'h2);
    wr(slc_pkg::IDX_DBG_T1, 32'h1);
    halt <= 2'b10;
    repeat (6) @(posedge hclk);
    check(32'(req), 32'h1);
    rd(slc_pkg::IDX_DBG_SRC, 32'h2);
    halt <= 2'b00;
    wr(slc_pkg::IDX_DBG_T1, 32'h0);
    repeat (6) @(posedge hclk);
    halt <= 2'b11;
    repeat (6) @(posedge hclk);
    check({req, halt_n}, 3'h1);
    repeat (4) @(posedge hclk);
    test_done;
  end
endmodule // switch_link_debug_config_bench
